// [phy_ctrl_reset_unit.sv]
// Purpose: chip reset, init flag and control of the two embedded phys
// Assumes: one 40 MHz clock, host on classic Wishbone, phy logic on clk_i
// Notes: pin and comparator inputs pass a two-stage synchroniser
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module phy_ctrl_reset_unit
   import phy_ctrl_pkg::*;
#(
   parameter int unsigned LV_HOLD_CYCLES = LV_HOLD_CYC
) (
   input wire logic clk_i,                 // 40 MHz system clock
   input wire logic rst_i,                 // synchronous reset, high
   input wire logic por_pulse_i,           // internal power-on pulse
   input wire logic ext_reset_n_i,         // reset pin, active low
   output logic sys_reset_o,               // combined system reset
   input wire logic wb_cyc_i,              // wishbone cycle
   input wire logic wb_stb_i,              // wishbone strobe
   input wire logic wb_we_i,               // wishbone write
   input wire logic [7:0] wb_adr_i,        // byte address
   input wire logic [3:0] wb_sel_i,        // byte enables
   input wire logic [31:0] wb_dat_i,       // write data
   output logic [31:0] wb_dat_o,           // read data
   output logic wb_ack_o,                  // acknowledge
   output logic regulator_standby_o,       // regulator low-current mode
   output logic [1:0] phy_reset_n_o,       // per-phy reset, low active
   output logic [1:0] phy_power_down_o,    // per-phy power-down
   output logic [1:0] phy_an_enable_o,     // per-phy negotiation on
   output logic [7:0] phy_advertise_o,     // per phy 100F,100H,10F,10H
   output logic [1:0] phy_force_100_o,     // forced speed is 100
   output logic [1:0] phy_force_full_o,    // forced full duplex
   output logic [1:0] phy_loopback_o,      // loopback active
   output logic [1:0] phy_power_save_o,    // power saving active
   output logic [1:0] phy_idle_pulse_o,    // send idle pulses
   input wire logic [1:0] phy_level_above_i, // rx level comparator
   output logic [1:0] signal_detect_o,     // signal detect to mii
   input wire logic [11:0] phy_indication_i, // six indications per phy
   output logic [2:0] led_o,               // led pins
   input wire logic [7:0] core_txd_i,      // mii tx data from core
   input wire logic [1:0] core_tx_en_i,    // mii tx enable from core
   output logic [7:0] phy_txd_o,           // tx data to pcs
   output logic [1:0] phy_tx_en_o,         // tx enable to pcs
   input wire logic [7:0] phy_rxd_i,       // decoded rx data from pcs
   input wire logic [1:0] phy_rx_dv_i,     // rx valid from pcs
   input wire logic [1:0] phy_rx_jk_i,     // pcs saw J/K delimiter
   output logic [7:0] core_rxd_o,          // mii rx data to core
   output logic [1:0] core_rx_dv_o,        // mii rx valid to core
   output logic mdc_o,                     // management clock
   output logic mdio_o,                    // management data out
   output logic mdio_oe_o,                 // management data enable
   input wire logic mdio_i                 // management data in
);
   // external reset pin synchroniser, cleared only by rst_i
   logic ext_meta_reg;
   logic ext_sync_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_meta_reg <= 1'b1;
         ext_sync_reg <= 1'b1;
      end else begin
         ext_meta_reg <= ext_reset_n_i;
         ext_sync_reg <= ext_meta_reg;
      end
   end

   // all three sources are equal; a low pin resets like power-on
   wire sys_rst = rst_i || por_pulse_i || !ext_sync_reg;
   assign sys_reset_o = sys_rst;

   // init sequencer: flag reads zero until the count expires
   logic [4:0] init_cnt_reg;
   logic init_done_reg;
   always_ff @(posedge clk_i) begin
      if (sys_rst) begin
         init_cnt_reg <= 5'd0;
         init_done_reg <= 1'b0;
      end else if (!init_done_reg) begin
         init_cnt_reg <= init_cnt_reg + 5'd1;
         init_done_reg <= (init_cnt_reg == 5'(INIT_CYCLES - 1));
      end
   end

   // host registers
   logic [31:0] ctl_reg;
   logic [31:0] led_sel_reg;
   logic [31:0] port_mdio_reg;

   // bus decode; unmapped addresses ack with zero data and no effect
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr_req = req && wb_we_i;
   wire sel_init = (wb_adr_i == CHIP_INIT_STATUS_OFS);
   wire sel_ctl = (wb_adr_i == PHY_CONTROL_OFS);
   wire sel_led = (wb_adr_i == LED_SELECT_OFS);
   wire sel_port = (wb_adr_i == PHY_PORT_MDIO_OFS);
   wire sel_cmd = (wb_adr_i == MDIO_RW_COMMAND_OFS);

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // management command decode; commands while busy are dropped
   logic md_busy;
   logic [15:0] md_rdata;
   wire [31:0] cmd_w = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
   wire md_write_cmd = wr_req && sel_cmd && cmd_w[MDIO_WRITE_BIT];
   wire md_read_cmd = wr_req && sel_cmd && cmd_w[MDIO_READ_BIT];
   wire md_start = (md_write_cmd || md_read_cmd) && !md_busy;
   wire [4:0] md_phy = port_mdio_reg[MDIO_PHY_LSB +: 5];
   wire [4:0] md_reg = port_mdio_reg[MDIO_REG_LSB +: 5];
   wire [15:0] md_wdata = port_mdio_reg[MDIO_WDATA_LSB +: 16];

   // read mux
   wire [31:0] init_rd = {15'h0000, init_done_reg, 16'h0000};
   wire [31:0] cmd_rd = {md_busy, 15'h0000, md_rdata};
   wire [31:0] rd_mux = sel_init ? init_rd :
                        sel_ctl ? ctl_reg :
                        sel_led ? led_sel_reg :
                        sel_port ? port_mdio_reg :
                        sel_cmd ? cmd_rd : 32'h0000_0000;

   // one wait state: ack in the cycle after the request, then drop
   always_ff @(posedge clk_i) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= (req && !wb_we_i) ? rd_mux : 32'h0000_0000;
      end
   end

   // register writes; the init status register has no writable bits
   always_ff @(posedge clk_i) begin
      if (sys_rst) begin
         ctl_reg <= PHY_CONTROL_RST;
         led_sel_reg <= LED_SELECT_RST;
         port_mdio_reg <= 32'h0000_0000;
      end else if (wr_req) begin
         if (sel_ctl) begin
            ctl_reg <= merge(ctl_reg, wb_dat_i, wb_sel_i);
         end
         if (sel_led) begin
            led_sel_reg <= merge(led_sel_reg, wb_dat_i, wb_sel_i);
         end
         if (sel_port && !md_busy) begin
            port_mdio_reg <= merge(port_mdio_reg, wb_dat_i, wb_sel_i);
         end
      end
   end

   assign regulator_standby_o = ctl_reg[REG_STANDBY_BIT];
   wire save_sw = ctl_reg[SAVE_SW_CTRL_BIT];

   // standard serial management frames reach every phy register
   mdio_frame_engine u_mdio (
      .clk_i(clk_i),
      .rst_i(sys_rst),
      .start_i(md_start),
      .write_i(md_write_cmd),
      .phy_i(md_phy),
      .reg_i(md_reg),
      .wdata_i(md_wdata),
      .busy_o(md_busy),
      .rdata_o(md_rdata),
      .mdc_o(mdc_o),
      .mdio_o(mdio_o),
      .mdio_oe_o(mdio_oe_o),
      .mdio_i(mdio_i)
   );

   // comparator synchronisers
   logic [1:0] lvl_meta_reg;
   logic [1:0] lvl_sync_reg;
   always_ff @(posedge clk_i) begin
      lvl_meta_reg <= phy_level_above_i;
      lvl_sync_reg <= lvl_meta_reg;
   end

   // per-phy control, datapath and status
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_phy
         localparam int B = p * PHY_FIELD_STRIDE;
         wire [2:0] opmode = ctl_reg[B+OPMODE_LSB +: 3];
         wire [4:0] phy_id = ctl_reg[B+PHY_ID_LSB +: 5];
         wire forced = opmode[2];
         logic bmcr_pd_reg;
         logic bmcr_lb_reg;
         logic jk_seen_reg;

         // track power-down and loopback bits written through management
         wire bmcr_hit = md_start && md_write_cmd && md_reg == BMCR_INDEX && md_phy == phy_id;
         always_ff @(posedge clk_i) begin
            if (sys_rst) begin
               bmcr_pd_reg <= 1'b0;
               bmcr_lb_reg <= 1'b0;
            end else if (bmcr_hit) begin
               bmcr_pd_reg <= md_wdata[BMCR_PD_BIT];
               bmcr_lb_reg <= md_wdata[BMCR_LB_BIT];
            end
         end

         // soft reset bit is low-true; system reset also holds it
         assign phy_reset_n_o[p] = ctl_reg[B+SOFT_RESET_BIT] && !sys_rst;
         assign phy_power_down_o[p] = ctl_reg[B+POWER_DOWN_BIT] || bmcr_pd_reg;

         // opmode decode: top bit forces, 011 turns negotiation off, else negotiation with an ability set
         assign phy_an_enable_o[p] = !forced && opmode[1:0] != 2'b11;
         assign phy_advertise_o[p*4 +: 4] = forced ? 4'h0 :
                                          (opmode[1:0] == 2'b00) ? 4'hF :
                                          (opmode[1:0] == 2'b01) ? 4'hC :
                                          (opmode[1:0] == 2'b10) ? 4'h3 : 4'h0;
         assign phy_force_100_o[p] = forced && !opmode[1];
         assign phy_force_full_o[p] = forced && !opmode[0];
         wire mode100 = !(forced && opmode[1]);

         signal_detect_hold #(
            .HOLD_CYCLES(16'(LV_HOLD_CYCLES))
         ) u_lv (
            .clk_i(clk_i),
            .rst_i(sys_rst),
            .level_i(lvl_sync_reg[p]),
            .mode100_i(mode100),
            .detect_o(signal_detect_o[p])
         );

         // auto mode saves power whenever no cable signal is seen
         assign phy_power_save_o[p] = save_sw ? ctl_reg[B+POWER_SAVE_BIT] :
                                      !signal_detect_o[p];
         assign phy_idle_pulse_o[p] = phy_power_save_o[p];

         // loopback keeps the line quiet and returns core tx to core rx
         wire lb = ctl_reg[B+LOOPBACK_BIT] || bmcr_lb_reg;
         assign phy_loopback_o[p] = lb;
         assign phy_txd_o[p*4 +: 4] = core_txd_i[p*4 +: 4];
         assign phy_tx_en_o[p] = core_tx_en_i[p] && !lb;

         // pcs data opens to the core only once J/K was seen this frame
         always_ff @(posedge clk_i) begin
            if (sys_rst) begin
               jk_seen_reg <= 1'b0;
            end else begin
               jk_seen_reg <= phy_rx_dv_i[p] && (jk_seen_reg || phy_rx_jk_i[p]);
            end
         end
         wire rx_ok = phy_rx_dv_i[p] && (jk_seen_reg || phy_rx_jk_i[p]);

         always_ff @(posedge clk_i) begin
            if (sys_rst) begin
               core_rxd_o[p*4 +: 4] <= 4'h0;
               core_rx_dv_o[p] <= 1'b0;
            end else begin
               core_rxd_o[p*4 +: 4] <= lb ? core_txd_i[p*4 +: 4] :
                                     rx_ok ? phy_rxd_i[p*4 +: 4] : 4'h0;
               core_rx_dv_o[p] <= lb ? core_tx_en_i[p] : rx_ok;
            end
         end
      end
   endgenerate

   // led routing: any indication of either phy onto each pin
   genvar l;
   generate
      for (l = 0; l < LED_COUNT; l++) begin : g_led
         wire [2:0] src = led_sel_reg[l*4 +: 3];
         wire [5:0] ind = led_sel_reg[l*4+3] ? phy_indication_i[11:6] : phy_indication_i[5:0];
         wire on = (src < 3'd6) && ind[src];
         always_ff @(posedge clk_i) begin
            if (sys_rst) begin
               led_o[l] <= 1'b0;
            end else begin
               led_o[l] <= on;
            end
         end
      end
   endgenerate
endmodule

// [phy_ctrl_pkg.sv]
// Purpose: shared constants for the phy control and reset unit
// Assumes: 40 MHz system clock, 32-bit classic Wishbone register bus
// Notes: offsets are byte addresses, one aligned word per register
package phy_ctrl_pkg;
   localparam int unsigned CLK_MHZ = 40;
   // register byte offsets
   localparam logic [7:0] CHIP_INIT_STATUS_OFS = 8'h00;
   localparam logic [7:0] PHY_CONTROL_OFS = 8'h04;
   localparam logic [7:0] LED_SELECT_OFS = 8'h08;
   localparam logic [7:0] PHY_PORT_MDIO_OFS = 8'h0C;
   localparam logic [7:0] MDIO_RW_COMMAND_OFS = 8'h10;
   // chip_init_status_reg
   localparam int INIT_DONE_BIT = 16;
   localparam int unsigned INIT_CYCLES = 16;
   // phy_control_reg, per-phy fields sit at base 0 (phy0) and 16 (phy1)
   localparam int PHY_FIELD_STRIDE = 16;
   localparam int SOFT_RESET_BIT = 0;
   localparam int POWER_DOWN_BIT = 1;
   localparam int OPMODE_LSB = 2;
   localparam int LOOPBACK_BIT = 5;
   localparam int PHY_ID_LSB = 6;
   localparam int POWER_SAVE_BIT = 13;
   localparam int SAVE_SW_CTRL_BIT = 15;
   localparam int REG_STANDBY_BIT = 31;
   localparam logic [31:0] PHY_CONTROL_RST = 32'h0001_0801;
   // led_select_reg: 4 bits per led, [2:0] indication, [3] phy
   localparam int LED_COUNT = 3;
   localparam logic [31:0] LED_SELECT_RST = 32'h0000_0135;
   // phy_port_mdio_reg
   localparam int MDIO_WDATA_LSB = 0;
   localparam int MDIO_REG_LSB = 16;
   localparam int MDIO_PHY_LSB = 24;
   // mdio_rw_command_reg
   localparam int MDIO_READ_BIT = 0;
   localparam int MDIO_WRITE_BIT = 1;
   localparam int MDIO_BUSY_BIT = 31;
   // basic mode control register, index and bits inside the phy
   localparam logic [4:0] BMCR_INDEX = 5'h00;
   localparam int BMCR_PD_BIT = 11;
   localparam int BMCR_LB_BIT = 14;
   // timing
   localparam int unsigned LV_HOLD_NS = 722000;
   localparam int unsigned LV_HOLD_CYC = LV_HOLD_NS * CLK_MHZ / 1000;
   localparam int unsigned MDC_HALF_CYC = 8;
   // mdio frame engine states, gray along idle-low-high-done
   typedef enum logic [1:0] {
      MD_IDLE = 2'b00,
      MD_LOW = 2'b01,
      MD_HIGH = 2'b11,
      MD_DONE = 2'b10
   } mdio_state_e;
endpackage

// [signal_detect_hold.sv]
// Purpose: stretches the received-level comparator into signal detect
// Assumes: level_i already synchronised
// Notes: hold only applies in 100BASE-TX operation
`timescale 1ns/1ps
module signal_detect_hold #(
   parameter logic [15:0] HOLD_CYCLES = 16'd1000
) (
   input wire logic clk_i,    // system clock
   input wire logic rst_i,    // synchronous reset
   input wire logic level_i,  // level above threshold
   input wire logic mode100_i, // phy runs 100BASE-TX
   output logic detect_o      // signal detect towards mii
);
   logic [15:0] cnt_reg;
   wire hold_end = (cnt_reg == HOLD_CYCLES - 16'd1);

   // rise at once; in 100BASE-TX fall only after a full hold time of low level, else fall at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         detect_o <= 1'b0;
         cnt_reg <= 16'h0000;
      end else if (level_i) begin
         detect_o <= 1'b1;
         cnt_reg <= 16'h0000;
      end else if (!mode100_i) begin
         detect_o <= 1'b0;
      end else if (detect_o) begin
         detect_o <= !hold_end;
         cnt_reg <= hold_end ? 16'h0000 : cnt_reg + 16'd1;
      end
   end
endmodule

// [mdio_frame_engine.sv]
// Purpose: clause 22 management frame generator for indirect phy access
// Assumes: mdio_i comes from a pin and is synchronised here
// Notes: data changes with mdc low, read bits sampled at mdc rise
`timescale 1ns/1ps
module mdio_frame_engine
   import phy_ctrl_pkg::*;
(
   input wire logic clk_i,         // system clock
   input wire logic rst_i,         // synchronous reset
   input wire logic start_i,       // one-cycle start request
   input wire logic write_i,       // 1 write, 0 read
   input wire logic [4:0] phy_i,   // phy address
   input wire logic [4:0] reg_i,   // register address
   input wire logic [15:0] wdata_i, // write data
   output logic busy_o,            // frame in progress
   output logic [15:0] rdata_o,    // captured read data
   output logic mdc_o,             // management clock
   output logic mdio_o,            // data out
   output logic mdio_oe_o,         // high while driving
   input wire logic mdio_i         // data in from pin
);
   mdio_state_e state_reg;
   logic [63:0] shift_reg;
   logic [5:0] bit_reg;
   logic [3:0] div_reg;
   logic wr_reg;
   logic in_meta_reg;
   logic in_sync_reg;

   wire half_end = (div_reg == 4'(MDC_HALF_CYC - 1));
   wire in_data = (bit_reg >= 6'd48);

   // pin synchroniser, first stage feeds the second only
   always_ff @(posedge clk_i) begin
      in_meta_reg <= mdio_i;
      in_sync_reg <= in_meta_reg;
   end

   assign busy_o = (state_reg != MD_IDLE);
   assign mdc_o = (state_reg == MD_HIGH);
   assign mdio_o = shift_reg[63];
   // a read frees the line from turnaround on
   assign mdio_oe_o = (state_reg == MD_LOW || state_reg == MD_HIGH) &&
                      (wr_reg || bit_reg < 6'd46);

   // preamble, start, op, addresses, turnaround, data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= MD_IDLE;
         shift_reg <= 64'h0000_0000_0000_0000;
         bit_reg <= 6'd0;
         div_reg <= 4'h0;
         wr_reg <= 1'b0;
         rdata_o <= 16'h0000;
      end else begin
         div_reg <= (half_end || state_reg == MD_IDLE) ? 4'h0 : div_reg + 4'h1;
         case (state_reg)
            MD_IDLE: begin
               if (start_i) begin
                  wr_reg <= write_i;
                  shift_reg <= {32'hFFFF_FFFF, 2'b01, !write_i, write_i, phy_i, reg_i,
                                2'b10, write_i ? wdata_i : 16'hFFFF};
                  bit_reg <= 6'd0;
                  state_reg <= MD_LOW;
               end
            end
            MD_LOW: begin
               if (half_end) begin
                  state_reg <= MD_HIGH;
                  if (!wr_reg && in_data) begin
                     rdata_o <= {rdata_o[14:0], in_sync_reg};
                  end
               end
            end
            MD_HIGH: begin
               if (half_end) begin
                  shift_reg <= {shift_reg[62:0], 1'b1};
                  bit_reg <= bit_reg + 6'd1;
                  state_reg <= (bit_reg == 6'd63) ? MD_DONE : MD_LOW;
               end
            end
            MD_DONE: state_reg <= MD_IDLE;
            default: state_reg <= MD_IDLE;
         endcase
      end
   end
endmodule

// [phy_ctrl_checker_asserts.sv]
// Purpose: port checks for the phy control and reset unit
// Assumes: one clock, rst_i synchronous and high active
// Notes: bus answers one cycle after the request; mdc half period is 8 cycles
`timescale 1ns/1ps
module phy_ctrl_checker
   import phy_ctrl_pkg::*;
(
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic ext_reset_n_i, // reset pin
   input wire logic sys_reset_o, // combined reset
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_ack_o, // answer
   input wire logic [1:0] phy_reset_n_o, // phy resets
   input wire logic [1:0] phy_an_enable_o, // negotiation on
   input wire logic [7:0] phy_advertise_o, // abilities
   input wire logic [1:0] phy_loopback_o, // loopback
   input wire logic [1:0] phy_tx_en_o, // tx enable to pcs
   input wire logic [1:0] phy_level_above_i, // rx level
   input wire logic [1:0] signal_detect_o, // signal detect
   input wire logic mdc_o // management clock
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // steps shared by the properties below
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !sys_reset_o; endsequence
   sequence s_level; (phy_level_above_i[0] && !sys_reset_o) [*3]; endsequence
   sequence s_mdc_high; mdc_o [*8] ##1 !mdc_o; endsequence
   property p_ack_next; s_req |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("late ack");
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held");
   property p_rst_phy; sys_reset_o |-> phy_reset_n_o == 2'b00; endproperty
   a_rst_phy: assert property (p_rst_phy) else $error("phy not in reset");
   property p_ext; !ext_reset_n_i [*3] |-> sys_reset_o; endproperty
   a_ext: assert property (p_ext) else $error("pin ignored");
   property p_adv; !sys_reset_o |-> phy_an_enable_o[0] == (phy_advertise_o[3:0] != 4'h0);
   endproperty
   a_adv: assert property (p_adv) else $error("advertise mismatch");
   property p_lv; s_level |=> signal_detect_o[0]; endproperty
   a_lv: assert property (p_lv) else $error("no signal detect");
   property p_mdc; $rose(mdc_o) |-> s_mdc_high; endproperty
   a_mdc: assert property (p_mdc) else $error("bad mdc high");
   property p_loop; phy_loopback_o[0] |-> !phy_tx_en_o[0]; endproperty
   a_loop: assert property (p_loop) else $error("tx in loopback");
endmodule
bind phy_ctrl_reset_unit phy_ctrl_checker i_phy_ctrl_checker (.*);

// [mdio_phy_model.sv]
// Purpose: management side of an embedded phy for the bench
// Assumes: 64 mdc periods a frame, read data driven from the turnaround on
// Notes: a released line floats to the pull-up level
`timescale 1ns/1ps
module mdio_phy_model #(
   parameter logic [15:0] READ_DATA = 16'ha5c3
) (
   input wire logic mdc_i, // management clock
   input wire logic oe_i, // controller drives the line
   input wire logic line_i, // resolved line
   output logic drv_o = 1'b0, // model drives the line
   output logic bit_o = 1'b0, // value driven
   output logic [63:0] frame_o = '0 // bits of the last frame
);
   int n = 0;
   logic rd = 1'b0;
   // a frame starts whenever the controller takes the line
   always @(posedge oe_i) n = 0;
   // sample at each rise; read data leads by a bit to settle
   always @(posedge mdc_i) begin
      frame_o = {frame_o[62:0], line_i};
      n++;
      if (n == 36) rd = (frame_o[1:0] == 2'b10);
      drv_o = rd && n >= 47 && n < 64;
      bit_o = (n < 48) ? 1'b0 : READ_DATA[63 - n];
   end
endmodule

// [testbench.sv]
// Purpose: self-checking bench for the phy control and reset unit
// Assumes: 40 MHz clock, signal detect hold shortened to 20 cycles
// Notes: the phy model answers management reads
`timescale 1ns/1ps
module testbench
   import phy_ctrl_pkg::*;
;
   localparam logic [6:0] MODE_EXP [8] = '{7'h7c, 7'h70, 7'h4c, 7'h00, 7'h03, 7'h02, 7'h01, 7'h00};
   localparam logic [31:0] CTL_SET [4] = '{32'h0001_0002, 32'h0001_0021, 32'h0001_a001,
                                           32'h2001_8001};
   localparam logic [9:0] CTL_EXP [4] = '{10'h24f, 10'h31f, 10'h305, 10'h30a};
   logic clk_i = 1'b0, rst_i = 1'b1, por_pulse_i = 1'b0, ext_reset_n_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, mdio_i, m_drv, m_bit;
   logic wb_ack_o, sys_reset_o, regulator_standby_o, mdc_o, mdio_o, mdio_oe_o;
   logic [7:0] wb_adr_i = '0, core_txd_i = '0, phy_rxd_i = '0, phy_advertise_o, phy_txd_o, core_rxd_o;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = '0, wb_dat_o, seed = 32'h0000_961c, q;
   logic [1:0] core_tx_en_i = '0, phy_rx_dv_i = '0, phy_rx_jk_i = '0, phy_level_above_i = '0;
   logic [1:0] phy_reset_n_o, phy_power_down_o, phy_an_enable_o, phy_force_100_o, phy_force_full_o;
   logic [1:0] phy_loopback_o, phy_power_save_o, phy_idle_pulse_o, signal_detect_o, phy_tx_en_o;
   logic [1:0] core_rx_dv_o;
   logic [11:0] phy_indication_i = '0, prev_ind;
   logic [2:0] led_o;
   logic [63:0] frame, e, ptx, exp_q[$];
   int mismatches = 0, samples_checked = 0, cycles = 0;
   phy_ctrl_reset_unit #(.LV_HOLD_CYCLES(20)) i_phy_ctrl_reset_unit (.*);
   mdio_phy_model i_mdio_phy_model (.mdc_i(mdc_o), .oe_i(mdio_oe_o), .line_i(mdio_i),
      .drv_o(m_drv), .bit_o(m_bit), .frame_o(frame));
   // wire level from both drivers, pull-up when nobody drives
   assign mdio_i = mdio_oe_o ? mdio_o : (m_drv ? m_bit : 1'b1);
   always #12.5 clk_i = ~clk_i;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // random traffic and the run limit
   always @(posedge clk_i) begin
      seed = xs(seed);
      {core_txd_i, core_tx_en_i, phy_rxd_i, phy_rx_dv_i, phy_rx_jk_i} <= seed[21:0];
      phy_indication_i <= seed[31:20];
      prev_ind <= phy_indication_i;
      ptx <= {core_tx_en_i[0], core_txd_i[3:0]};
      cycles++;
      if (cycles == 12000) begin
         mismatches++;
         final_report();
      end
   end
   // read answers against the oldest note, masked
   always @(posedge clk_i) if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(wb_dat_o & e[63:32], e[31:0]);
   end
   // one classic cycle; the request holds until the answer edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [63:0] x, output logic [31:0] r);
      @(posedge clk_i);
      if (!we) exp_q.push_back(x);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, '0, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      wb(1'b0, a, '0, {m, x}, q);
   endtask
   task automatic poll();
      logic [31:0] r;
      r = 32'h8000_0000;
      while (r[31] !== 1'b0) wb(1'b0, MDIO_RW_COMMAND_OFS, '0, '0, r);
   endtask
   task automatic at(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(CHIP_INIT_STATUS_OFS, 32'h0001_0000, '0);
      rd(PHY_CONTROL_OFS, '1, PHY_CONTROL_RST);
      rd(LED_SELECT_OFS, '1, LED_SELECT_RST);
      at(20);
      wr(CHIP_INIT_STATUS_OFS, '0);
      rd(CHIP_INIT_STATUS_OFS, 32'h0001_0000, 32'h0001_0000);
      wr(8'h40, '1);
      rd(8'h40, '1, '0);
      for (int m = 0; m < 8; m++) begin
         wr(PHY_CONTROL_OFS, {m[0], 10'h0, 3'(7 - m), 2'b01, 11'h0, 3'(m), 2'b01});
         at(0);
         check({phy_an_enable_o[0], phy_advertise_o[3:0], phy_force_100_o[0],
                phy_force_full_o[0]}, MODE_EXP[m]);
         check({phy_an_enable_o[1], phy_advertise_o[7:4], phy_force_100_o[1],
                phy_force_full_o[1]}, MODE_EXP[7 - m]);
         check({regulator_standby_o, phy_reset_n_o}, {m[0], 2'b11});
      end
      for (int i = 0; i < 4; i++) begin
         wr(PHY_CONTROL_OFS, CTL_SET[i]);
         at(0);
         check({phy_reset_n_o, phy_power_down_o, phy_loopback_o, phy_power_save_o,
                phy_idle_pulse_o}, CTL_EXP[i]);
         check({phy_tx_en_o, phy_txd_o}, {core_tx_en_i & ~CTL_EXP[i][5:4], core_txd_i});
         if (i == 1) check({core_rx_dv_o[0], core_rxd_o[3:0]}, ptx);
      end
      for (int k = 0; k < 6; k++) begin
         wr(LED_SELECT_OFS, {24'h0, 1'b1, 3'(5 - k), 1'b0, 3'(k)});
         at(2);
         check(led_o, {prev_ind[0], prev_ind[11 - k], prev_ind[k]});
      end
      wr(PHY_CONTROL_OFS, 32'h0001_0011);
      phy_level_above_i <= 2'b01;
      at(6);
      check({signal_detect_o, phy_power_save_o}, 4'b0110);
      @(posedge clk_i);
      phy_level_above_i <= 2'b00;
      at(10);
      check(signal_detect_o, 2'b01);
      at(20);
      check({signal_detect_o, phy_power_save_o}, 4'b0011);
      @(posedge clk_i);
      por_pulse_i <= 1'b1;
      at(0);
      check(sys_reset_o, 1'b1);
      @(posedge clk_i);
      por_pulse_i <= 1'b0;
      rd(PHY_CONTROL_OFS, '1, PHY_CONTROL_RST);
      wr(PHY_CONTROL_OFS, 32'h0001_0011);
      @(posedge clk_i);
      ext_reset_n_i <= 1'b0;
      at(3);
      check(sys_reset_o, 1'b1);
      @(posedge clk_i);
      ext_reset_n_i <= 1'b1;
      rd(CHIP_INIT_STATUS_OFS, 32'h0001_0000, '0);
      rd(PHY_CONTROL_OFS, '1, PHY_CONTROL_RST);
      wr(PHY_CONTROL_OFS, 32'h0001_0001);
      wr(PHY_PORT_MDIO_OFS, 32'h0000_4800);
      wr(MDIO_RW_COMMAND_OFS, 32'h0000_0002);
      rd(MDIO_RW_COMMAND_OFS, 32'h8000_0000, 32'h8000_0000);
      poll();
      check(frame, {32'hffff_ffff, 4'b0101, 10'h000, 2'b10, 16'h4800});
      check({phy_loopback_o[0], phy_power_down_o[0]}, 2'b11);
      wr(PHY_PORT_MDIO_OFS, 32'h0102_0000);
      wr(MDIO_RW_COMMAND_OFS, 32'h0000_0001);
      poll();
      rd(MDIO_RW_COMMAND_OFS, 32'h8000_ffff, 32'h0000_a5c3);
      check(frame, {32'hffff_ffff, 4'b0110, 5'd1, 5'd2, 2'b10, 16'ha5c3});
      final_report();
   end
endmodule
